// ===== shared/ppx_pkg.sv
package ppx_pkg;

  localparam int NUM_CH = 2;
  localparam int MAX_PROTO = 8;
  localparam int ADDR_W = 18;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CH1_LINE = 16'h0092;
  localparam logic [15:0] IDX_CH2_LINE = 16'h0132;
  localparam logic [15:0] IDX_CH1_MON = 16'h2018;
  localparam logic [15:0] IDX_CH2_MON = 16'h2118;
  localparam logic [15:0] IDX_CH1_CANCEL = 16'h4040;
  localparam logic [15:0] IDX_CH1_STATUS = 16'h4041;
  localparam logic [15:0] IDX_CH2_CANCEL = 16'h4050;
  localparam logic [15:0] IDX_CH2_STATUS = 16'h4051;

  localparam logic [15:0] PROTO_MIN = 16'h0001;
  localparam logic [15:0] PROTO_MAX = 16'h0080;
  localparam logic [15:0] SP_RX_CLEAR = 16'h00C9;
  localparam logic [15:0] SP_MON_START = 16'h00CA;
  localparam logic [15:0] SP_MON_STOP = 16'h00CB;
  localparam logic [15:0] SP_DTR_ON = 16'h00CC;
  localparam logic [15:0] SP_DTR_OFF = 16'h00CD;
  localparam logic [15:0] SP_RTS_ON = 16'h00CE;
  localparam logic [15:0] SP_RTS_OFF = 16'h00CF;
  localparam logic [15:0] SP_BASE = 16'h00C8;

  localparam logic [15:0] MON_START = 16'h0001;
  localparam logic [15:0] MON_STOP = 16'h0000;
  localparam logic [15:0] CANCEL_NONE = 16'h0000;
  localparam logic [15:0] CANCEL_REQ = 16'h0001;
  localparam logic [15:0] CANCEL_DONE = 16'h0002;

  localparam logic [15:0] RESULT_OK = 16'h0000;
  localparam logic [15:0] ERR_REINIT = 16'h7FF0;
  localparam logic [15:0] ERR_FOREIGN = 16'h7FF2;
  localparam logic [15:0] ERR_CANCEL = 16'h7D10;
  localparam logic [15:0] ERR_PARAM = 16'h7D20;

  localparam int LINE_DTR_BIT = 0;
  localparam int LINE_RTS_BIT = 1;

  localparam logic [15:0] STAT_IDLE = 16'h0000;
  localparam logic [15:0] STAT_RUN = 16'h0001;
  localparam logic [15:0] STAT_OK = 16'h0002;
  localparam logic [15:0] STAT_ERR = 16'h0003;

  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DISPATCH = 3'h1,
    ST_WAIT = 3'h2,
    ST_FINISH = 3'h3,
    ST_PULSE = 3'h4
  } ppx_state_e;

  typedef enum logic [1:0] {
    OI_REINIT = 2'h0,
    OI_BUF_RECV = 2'h1,
    OI_FOREIGN = 2'h2,
    OI_NONE = 2'h3
  } ppx_other_e;

  typedef struct packed {
    logic vld;
    logic [15:0] ch;
    logic [15:0] count;
    logic [MAX_PROTO-1:0][15:0] protos;
  } ppx_run_req_s;

  typedef struct packed {
    logic vld;
    logic [15:0] ch;
    ppx_other_e kind;
  } ppx_other_req_s;

  typedef struct packed {
    logic ack;
    logic [15:0] code;
  } ppx_other_rsp_s;

  typedef struct packed {
    logic start;
    logic abort;
    logic [15:0] proto;
  } ppx_eng_req_s;

  typedef struct packed {
    logic done;
    logic err;
    logic [15:0] code;
  } ppx_eng_rsp_s;

  typedef struct packed {
    logic done;
    logic err;
    logic [15:0] result;
    logic [15:0] executed;
    logic rxClear;
    logic histVld;
    logic [2:0] histKey;
    logic dtr;
    logic rts;
  } ppx_chan_out_s;

endpackage

// ===== src/ppx_executor.sv
`timescale 1ns/1ns
module ppx_executor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ppx_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scanEnd,
  input wire logic [ppx_pkg::NUM_CH-1:0] predefMode,
  input wire ppx_pkg::ppx_run_req_s runReq,
  input wire ppx_pkg::ppx_other_req_s otherReq,
  output ppx_pkg::ppx_other_rsp_s otherRsp,
  input wire ppx_pkg::ppx_eng_rsp_s [ppx_pkg::NUM_CH-1:0] engRsp,
  output ppx_pkg::ppx_eng_req_s [ppx_pkg::NUM_CH-1:0] engReq,
  output ppx_pkg::ppx_chan_out_s [ppx_pkg::NUM_CH-1:0] chanOut
);

  typedef struct packed {
    ppx_pkg::ppx_state_e state;
    logic [3:0] idx;
    logic [3:0] count;
    logic [ppx_pkg::MAX_PROTO-1:0][15:0] protos;
    logic errPend;
    logic [15:0] lineCtrl;
    logic [15:0] monCtrl;
    logic [15:0] cancel;
    logic [15:0] status;
    ppx_pkg::ppx_eng_req_s eng;
    ppx_pkg::ppx_chan_out_s out;
  } ppx_chan_s;

  typedef struct packed {
    ppx_chan_s [ppx_pkg::NUM_CH-1:0] ch;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    ppx_pkg::ppx_other_rsp_s other;
  } ppx_state_s;

  ppx_state_s st_q;
  ppx_state_s st_d;

  function automatic logic isSpecial(input logic [15:0] p);
    isSpecial = (p >= ppx_pkg::SP_RX_CLEAR) && (p <= ppx_pkg::SP_RTS_OFF);
  endfunction

  function automatic logic isLegal(input logic [15:0] p);
    isLegal = ((p >= ppx_pkg::PROTO_MIN) && (p <= ppx_pkg::PROTO_MAX)) || isSpecial(p);
  endfunction

  function automatic logic [15:0] readReg(input ppx_state_s s, input logic [15:0] idx);
    readReg = 16'h0000;
    unique case (idx)
      ppx_pkg::IDX_CH1_LINE: readReg = s.ch[0].lineCtrl;
      ppx_pkg::IDX_CH2_LINE: readReg = s.ch[1].lineCtrl;
      ppx_pkg::IDX_CH1_MON: readReg = s.ch[0].monCtrl;
      ppx_pkg::IDX_CH2_MON: readReg = s.ch[1].monCtrl;
      ppx_pkg::IDX_CH1_CANCEL: readReg = s.ch[0].cancel;
      ppx_pkg::IDX_CH2_CANCEL: readReg = s.ch[1].cancel;
      ppx_pkg::IDX_CH1_STATUS: readReg = s.ch[0].status;
      ppx_pkg::IDX_CH2_STATUS: readReg = s.ch[1].status;
      default: readReg = 16'h0000;
    endcase
  endfunction

  function automatic logic isMapped(input logic [15:0] idx);
    isMapped = (idx == ppx_pkg::IDX_CH1_LINE) || (idx == ppx_pkg::IDX_CH2_LINE) ||
               (idx == ppx_pkg::IDX_CH1_MON) || (idx == ppx_pkg::IDX_CH2_MON) ||
               (idx == ppx_pkg::IDX_CH1_CANCEL) || (idx == ppx_pkg::IDX_CH2_CANCEL) ||
               (idx == ppx_pkg::IDX_CH1_STATUS) || (idx == ppx_pkg::IDX_CH2_STATUS);
  endfunction

  logic [15:0] regIdx;
  logic aligned;
  logic access;

  assign regIdx = paddr[ppx_pkg::ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign access = psel && penable;

  always_comb begin
    logic [15:0] p;
    logic bad;
    logic last;
    logic [3:0] nextIdx;
    logic [15:0] chNum;
    logic busy;
    p = 16'h0000;
    bad = 1'b0;
    last = 1'b0;
    nextIdx = 4'h0;
    chNum = 16'h0000;
    busy = 1'b0;
    st_d = st_q;

    // APB slave: one wait state, write lands on the completing edge
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    if (access && !st_q.pready) begin
      st_d.pready = 1'b1;
      st_d.pslverr = !(aligned && isMapped(regIdx));
      st_d.prdata = {16'h0000, readReg(st_q, regIdx)};
      if (!(aligned && isMapped(regIdx))) begin
        st_d.prdata = 32'h0000_0000;
      end
    end
    if (access && st_q.pready && pwrite && aligned) begin
      unique case (regIdx)
        ppx_pkg::IDX_CH1_LINE: st_d.ch[0].lineCtrl = pwdata[15:0];
        ppx_pkg::IDX_CH2_LINE: st_d.ch[1].lineCtrl = pwdata[15:0];
        ppx_pkg::IDX_CH1_MON: st_d.ch[0].monCtrl = pwdata[15:0];
        ppx_pkg::IDX_CH2_MON: st_d.ch[1].monCtrl = pwdata[15:0];
        ppx_pkg::IDX_CH1_CANCEL: st_d.ch[0].cancel = pwdata[15:0];
        ppx_pkg::IDX_CH2_CANCEL: st_d.ch[1].cancel = pwdata[15:0];
        default: st_d.pslverr = 1'b0;
      endcase
    end

    // Reinit and foreign instructions checked against a running request on the same channel; buffer receive always answers OK
    st_d.other.ack = 1'b0;
    if (otherReq.vld) begin
      st_d.other.ack = 1'b1;
      st_d.other.code = ppx_pkg::RESULT_OK;
      for (int c = 0; c < ppx_pkg::NUM_CH; c++) begin
        chNum = 16'(c + 1);
        if ((otherReq.ch == chNum) && (st_q.ch[c].state != ppx_pkg::ST_IDLE)) begin
          busy = 1'b1;
        end
      end
      if (busy && (otherReq.kind == ppx_pkg::OI_REINIT)) begin
        st_d.other.code = ppx_pkg::ERR_REINIT;
      end else if (busy && (otherReq.kind == ppx_pkg::OI_FOREIGN)) begin
        st_d.other.code = ppx_pkg::ERR_FOREIGN;
      end
    end

    for (int c = 0; c < ppx_pkg::NUM_CH; c++) begin
      chNum = 16'(c + 1);
      st_d.ch[c].eng.start = 1'b0;
      st_d.ch[c].eng.abort = 1'b0;
      st_d.ch[c].out.rxClear = 1'b0;
      st_d.ch[c].out.histVld = 1'b0;
      p = st_q.ch[c].protos[st_q.ch[c].idx[2:0]];
      nextIdx = st_q.ch[c].idx + 4'h1;
      last = (nextIdx == st_q.ch[c].count);
      unique case (st_q.ch[c].state)
        ppx_pkg::ST_IDLE: begin
          // Busy channels never reach here; cancel word 1 blocks the start
          if (runReq.vld && (runReq.ch == chNum) &&
              (st_q.ch[c].cancel != ppx_pkg::CANCEL_REQ)) begin
            bad = (runReq.count < 16'h0001) || (runReq.count > 16'(ppx_pkg::MAX_PROTO));
            for (int i = 0; i < ppx_pkg::MAX_PROTO; i++) begin
              if ((16'(i) < runReq.count) && !isLegal(runReq.protos[i])) begin
                bad = 1'b1;
              end
            end
            st_d.ch[c].protos = runReq.protos;
            st_d.ch[c].count = runReq.count[3:0];
            st_d.ch[c].idx = 4'h0;
            if (bad) begin
              st_d.ch[c].out.result = ppx_pkg::ERR_PARAM;
              st_d.ch[c].out.executed = 16'h0000;
              st_d.ch[c].errPend = 1'b1;
              st_d.ch[c].status = ppx_pkg::STAT_ERR;
              st_d.ch[c].state = ppx_pkg::ST_FINISH;
            end else begin
              st_d.ch[c].status = ppx_pkg::STAT_RUN;
              st_d.ch[c].state = ppx_pkg::ST_DISPATCH;
            end
          end
        end
        ppx_pkg::ST_DISPATCH: begin
          if (isSpecial(p)) begin
            // Built-in functions finish in one cycle
            unique case (p)
              ppx_pkg::SP_RX_CLEAR: st_d.ch[c].out.rxClear = 1'b1;
              ppx_pkg::SP_MON_START: st_d.ch[c].monCtrl = ppx_pkg::MON_START;
              ppx_pkg::SP_MON_STOP: st_d.ch[c].monCtrl = ppx_pkg::MON_STOP;
              ppx_pkg::SP_DTR_ON: st_d.ch[c].lineCtrl[ppx_pkg::LINE_DTR_BIT] = 1'b1;
              ppx_pkg::SP_DTR_OFF: st_d.ch[c].lineCtrl[ppx_pkg::LINE_DTR_BIT] = 1'b0;
              ppx_pkg::SP_RTS_ON: st_d.ch[c].lineCtrl[ppx_pkg::LINE_RTS_BIT] = 1'b1;
              default: st_d.ch[c].lineCtrl[ppx_pkg::LINE_RTS_BIT] = 1'b0;
            endcase
            st_d.ch[c].out.histVld = 1'b1;
            st_d.ch[c].out.histKey = 3'(p - ppx_pkg::SP_BASE);
            st_d.ch[c].out.result = ppx_pkg::RESULT_OK;
            st_d.ch[c].out.executed = {12'h000, nextIdx};
            st_d.ch[c].idx = nextIdx;
            if (last) begin
              st_d.ch[c].errPend = 1'b0;
              st_d.ch[c].status = ppx_pkg::STAT_OK;
              st_d.ch[c].state = ppx_pkg::ST_FINISH;
            end
          end else begin
            st_d.ch[c].eng.start = 1'b1;
            st_d.ch[c].eng.proto = p;
            st_d.ch[c].state = ppx_pkg::ST_WAIT;
          end
        end
        ppx_pkg::ST_WAIT: begin
          if ((st_q.ch[c].cancel == ppx_pkg::CANCEL_REQ) && predefMode[c]) begin
            st_d.ch[c].eng.abort = 1'b1;
            st_d.ch[c].cancel = ppx_pkg::CANCEL_DONE;
            st_d.ch[c].out.result = ppx_pkg::ERR_CANCEL;
            st_d.ch[c].out.executed = {12'h000, nextIdx};
            st_d.ch[c].errPend = 1'b1;
            st_d.ch[c].status = ppx_pkg::STAT_ERR;
            st_d.ch[c].state = ppx_pkg::ST_FINISH;
          end else if (engRsp[c].done) begin
            st_d.ch[c].out.result = engRsp[c].err ? engRsp[c].code : ppx_pkg::RESULT_OK;
            st_d.ch[c].out.executed = {12'h000, nextIdx};
            st_d.ch[c].idx = nextIdx;
            if (engRsp[c].err || last) begin
              st_d.ch[c].errPend = engRsp[c].err;
              st_d.ch[c].status = engRsp[c].err ? ppx_pkg::STAT_ERR : ppx_pkg::STAT_OK;
              st_d.ch[c].state = ppx_pkg::ST_FINISH;
            end else begin
              st_d.ch[c].state = ppx_pkg::ST_DISPATCH;
            end
          end
        end
        ppx_pkg::ST_FINISH: begin
          if (scanEnd) begin
            st_d.ch[c].out.done = 1'b1;
            st_d.ch[c].out.err = st_q.ch[c].errPend;
            st_d.ch[c].state = ppx_pkg::ST_PULSE;
          end
        end
        ppx_pkg::ST_PULSE: begin
          if (scanEnd) begin
            st_d.ch[c].out.done = 1'b0;
            st_d.ch[c].out.err = 1'b0;
            st_d.ch[c].state = ppx_pkg::ST_IDLE;
          end
        end
        default: begin
          st_d.ch[c].state = ppx_pkg::ST_IDLE;
        end
      endcase
      // Cancel seen while idle or in another mode is left untouched
      st_d.ch[c].out.dtr = st_d.ch[c].lineCtrl[ppx_pkg::LINE_DTR_BIT];
      st_d.ch[c].out.rts = st_d.ch[c].lineCtrl[ppx_pkg::LINE_RTS_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign otherRsp = st_q.other;

  generate
    for (genvar g = 0; g < ppx_pkg::NUM_CH; g++) begin : gCh
      assign engReq[g] = st_q.ch[g].eng;
      assign chanOut[g] = st_q.ch[g].out;
    end
  endgenerate

endmodule

// ===== test/ppx_engine_model.sv
`timescale 1ns/1ns
module ppx_engine_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] lat,
  input wire logic [1:0] failCh,
  input wire ppx_pkg::ppx_eng_req_s [1:0] engReq,
  output ppx_pkg::ppx_eng_rsp_s [1:0] engRsp
);
  logic [1:0][7:0] cntQ;
  logic [1:0] busyQ;
  // One protocol per channel; abort drops it with no answer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cntQ <= '0;
      busyQ <= '0;
      engRsp <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        engRsp[c] <= '0;
        if (engReq[c].abort) begin
          busyQ[c] <= 1'b0;
        end else if (engReq[c].start) begin
          busyQ[c] <= 1'b1;
          cntQ[c] <= lat;
        end else if (busyQ[c] && cntQ[c] == 8'h00) begin
          busyQ[c] <= 1'b0;
          engRsp[c].done <= 1'b1;
          engRsp[c].err <= failCh[c];
          engRsp[c].code <= failCh[c] ? 16'h7E00 : 16'h0000;
        end else if (busyQ[c]) begin
          cntQ[c] <= cntQ[c] - 8'h01;
        end
      end
    end
  end
endmodule

// ===== test/ppx_executor_checker.sv
`timescale 1ns/1ns
module ppx_executor_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scanEnd,
  input wire logic [ppx_pkg::NUM_CH-1:0] predefMode,
  input wire ppx_pkg::ppx_run_req_s runReq,
  input wire ppx_pkg::ppx_other_req_s otherReq,
  input wire ppx_pkg::ppx_other_rsp_s otherRsp,
  input wire ppx_pkg::ppx_eng_req_s [ppx_pkg::NUM_CH-1:0] engReq,
  input wire ppx_pkg::ppx_chan_out_s [ppx_pkg::NUM_CH-1:0] chanOut
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_doneRise;
    $rose(chanOut[0].done) |-> $past(scanEnd);
  endproperty
  a_doneRise: assert property (p_doneRise) else $error("done rose off scan end");
  property p_doneFall;
    chanOut[0].done && scanEnd |=> !chanOut[0].done;
  endproperty
  a_doneFall: assert property (p_doneFall) else $error("done held past scan end");
  property p_fallSecond;
    $fell(chanOut[1].done) |-> $past(scanEnd);
  endproperty
  a_fallSecond: assert property (p_fallSecond) else $error("done fell off scan end");
  property p_errDone;
    chanOut[1].err |-> chanOut[1].done;
  endproperty
  a_errDone: assert property (p_errDone) else $error("error flag without done");
  property p_resultErr;
    $rose(chanOut[0].done) |-> chanOut[0].err == (chanOut[0].result != 16'h0000);
  endproperty
  a_resultErr: assert property (p_resultErr) else $error("result and flag differ");
  property p_execMax;
    chanOut[0].done |-> chanOut[0].executed <= 16'h0008;
  endproperty
  a_execMax: assert property (p_execMax) else $error("executed count too big");
  property p_abortMode;
    engReq[0].abort |-> $past(predefMode[0]);
  endproperty
  a_abortMode: assert property (p_abortMode) else $error("abort outside mode");
  property p_busyDrop;
    runReq.vld && runReq.ch == 16'h0001 && chanOut[0].done |=> !engReq[0].start [*2];
  endproperty
  a_busyDrop: assert property (p_busyDrop) else $error("busy request started");
  property p_bufRecv;
    otherReq.vld && otherReq.kind == ppx_pkg::OI_BUF_RECV |=> otherRsp.ack && otherRsp.code == 16'h0000;
  endproperty
  a_bufRecv: assert property (p_bufRecv) else $error("buffer receive refused");
  property p_dtrCause;
    $rose(chanOut[0].dtr) |-> chanOut[0].histVld || $past(chanOut[0].histVld);
  endproperty
  a_dtrCause: assert property (p_dtrCause) else $error("line bit without special");
endmodule
bind ppx_executor ppx_executor_checker chk (.clk(clk), .rstn(rstn), .scanEnd(scanEnd),
  .predefMode(predefMode), .runReq(runReq), .otherReq(otherReq), .otherRsp(otherRsp),
  .engReq(engReq), .chanOut(chanOut));

// ===== test/ppx_executor_tb.sv
`timescale 1ns/1ns
module ppx_executor_tb;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, scanEnd = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, slvErr;
  logic [1:0] predefMode = 2'h3, failCh = 2'h0;
  logic [7:0] lat = 8'h02;
  logic [15:0] regs [4] = '{16'h0092, 16'h2018, 16'h4040, 16'h4051};
  ppx_pkg::ppx_run_req_s runReq = '0;
  ppx_pkg::ppx_other_req_s otherReq = '0;
  ppx_pkg::ppx_other_rsp_s otherRsp;
  ppx_pkg::ppx_eng_rsp_s [1:0] engRsp;
  ppx_pkg::ppx_eng_req_s [1:0] engReq;
  ppx_pkg::ppx_chan_out_s [1:0] chanOut;
  int bad_count = 0, compares = 0, cyc = 0, starts = 0, hist = 0;
  logic [15:0] lastProto0 = 16'h0000, lastProto1 = 16'h0000;
  logic [2:0] lastKey = 3'h0;
  ppx_executor uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scanEnd(scanEnd), .predefMode(predefMode), .runReq(runReq), .otherReq(otherReq),
    .otherRsp(otherRsp), .engRsp(engRsp), .engReq(engReq), .chanOut(chanOut));
  ppx_engine_model eng (.clk(clk), .rstn(rstn), .lat(lat), .failCh(failCh), .engReq(engReq),
    .engRsp(engRsp));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    scanEnd <= (cyc % 16 == 15);
    starts <= starts + int'(engReq[0].start);
    hist <= hist + int'(chanOut[0].histVld) + int'(chanOut[0].rxClear);
    if (engReq[0].start) begin
      lastProto0 <= engReq[0].proto;
    end
    if (engReq[1].start) begin
      lastProto1 <= engReq[1].proto;
    end
    if (chanOut[0].histVld) begin
      lastKey <= chanOut[0].histKey;
    end
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic run(input logic [15:0] ch, n, input logic [127:0] p);
    runReq <= {1'b1, ch, n, p};
    @(posedge clk);
    runReq.vld <= 1'b0;
    @(posedge clk);
  endtask
  task automatic oth(input logic [15:0] ch, input ppx_pkg::ppx_other_e k, input logic [15:0] e);
    otherReq <= {1'b1, ch, k};
    @(posedge clk);
    otherReq.vld <= 1'b0;
    @(posedge clk);
    check("other code", otherRsp.code, e);
    check("other ack", otherRsp.ack, 1'b1);
  endtask
  task automatic fin(input int c, input logic e, input logic [15:0] res, n);
    int k = 0;
    while (chanOut[c].done !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    check("done", chanOut[c].done, 1'b1);
    check("err", chanOut[c].err, e);
    check("result", chanOut[c].result, res);
    check("executed", chanOut[c].executed, n);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, 16'h0001, '0);
    check("unmapped", {slvErr, rd[30:0]}, 32'h80000000);
    foreach (regs[i]) begin
      apb(1'b0, regs[i], '0);
      check("reset word", rd, '0);
    end
    $display("test registers done");
    failCh <= 2'h2;
    run(16'h0002, 16'h0001, 128'h0007);
    run(16'h0001, 16'h0005, 128'h0003_00CE_00CC_00CA_00C9);
    fin(1, 1'b1, 16'h7E00, 16'h0001);
    fin(0, 1'b0, 16'h0000, 16'h0005);
    run(16'h0001, 16'h0001, 128'h0004);
    repeat (20) @(posedge clk);
    check("starts", starts, 1);
    check("history", hist, 5);
    check("dtr rts", {chanOut[0].rts, chanOut[0].dtr}, 2'h3);
    apb(1'b0, 16'h0092, '0);
    check("line word", rd, 32'h3);
    apb(1'b0, 16'h2018, '0);
    check("monitor word", rd, 32'h1);
    apb(1'b0, 16'h4051, '0);
    check("status ch2", rd, 32'h3);
    check("proto ch1", lastProto0, 16'h0003);
    check("proto ch2", lastProto1, 16'h0007);
    check("key", lastKey, 3'h6);
    $display("test specials done");
    lat <= 8'h40;
    run(16'h0001, 16'h0004, 128'h0001_00CF_00CD_00CB);
    run(16'h0001, 16'h0001, 128'h0002);
    oth(16'h0001, ppx_pkg::OI_REINIT, 16'h7FF0);
    oth(16'h0001, ppx_pkg::OI_FOREIGN, 16'h7FF2);
    oth(16'h0001, ppx_pkg::OI_BUF_RECV, 16'h0000);
    oth(16'h0002, ppx_pkg::OI_REINIT, 16'h0000);
    apb(1'b0, 16'h4041, '0);
    check("status", rd, 32'h1);
    fin(0, 1'b0, 16'h0000, 16'h0004);
    repeat (20) @(posedge clk);
    check("starts", starts, 2);
    check("dtr rts", {chanOut[0].rts, chanOut[0].dtr}, 2'h0);
    apb(1'b0, 16'h2018, '0);
    check("monitor word", rd, 32'h0);
    apb(1'b0, 16'h4041, '0);
    check("status", rd, 32'h2);
    check("proto ch1", lastProto0, 16'h0001);
    check("proto ch2", lastProto1, 16'h0007);
    check("key", lastKey, 3'h7);
    $display("test busy done");
    run(16'h0001, 16'h0003, 128'h0003_0002_0001);
    while (starts < 3) @(posedge clk);
    apb(1'b1, 16'h4040, 32'h1);
    fin(0, 1'b1, 16'h7D10, 16'h0001);
    apb(1'b0, 16'h4040, '0);
    check("cancel word", rd, 32'h2);
    apb(1'b1, 16'h4040, 32'h0);
    while (chanOut[0].done === 1'b1) @(posedge clk);
    run(16'h0001, 16'h0001, 128'h00C9);
    fin(0, 1'b0, 16'h0000, 16'h0001);
    check("history", hist, 10);
    check("key", lastKey, 3'h1);
    check("starts", starts, 3);
    $display("test cancel done");
    repeat (20) @(posedge clk);
    predefMode <= 2'h2;
    run(16'h0001, 16'h0001, 128'h0005);
    apb(1'b1, 16'h4040, 32'h1);
    fin(0, 1'b0, 16'h0000, 16'h0001);
    predefMode <= 2'h3;
    repeat (20) @(posedge clk);
    apb(1'b0, 16'h4040, '0);
    check("cancel word", rd, 32'h1);
    run(16'h0001, 16'h0001, 128'h0005);
    repeat (40) @(posedge clk);
    check("starts", starts, 4);
    apb(1'b1, 16'h4040, 32'h0);
    run(16'h0001, 16'h0000, 128'h0005);
    fin(0, 1'b1, 16'h7D20, 16'h0000);
    $display("test refusals done");
    report_and_stop();
  end
endmodule
